/* src/stats_counters.sv */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - bank works only when the management interface is enabled
// - counters are 32 or 64 bits, 64 default; 64-bit ones read as two words
// - lower read captures upper half; next upper read returns it
// - upper read of another counter answers with error
// - all locations read-only; writes change nothing and error
// - build option decides whether reset clears counters
// - reads never clear; maximum value wraps to zero
// - counters 0 to 3 count internal events, possibly every cycle
// - decode logic gives one toggle bit for counters 4 to 43
// - each level change on a bit is one increment
// - edge detection on every bit, on the statistics clock
// - counters in memory, visited round robin, pending ones incremented
// - each update is one memory read and one write
// - sweep visits one member of each size set: the lowest flagged, else the base
module stats_counters
    import stats_pkg::*;
#(
    parameter bit MGMT_ENABLE    = 1'b1,
    parameter bit WIDE_COUNTERS  = 1'b1,
    parameter bit CLEAR_ON_RESET = 1'b1
)
(
    // clock, reset, enable
    input  wire logic                      clock_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      ce_i,
    // event sources
    input  wire logic [NUM_HF-1:0]         hf_inc_i,
    input  wire logic [NUM_LF-1:0]         inc_vec_i,
    // read window
    input  wire stats_pkg::stats_req_type  req_i,
    output stats_pkg::stats_resp_type      resp_o
);

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic rst_meta_q;
    logic rst_q;

    // two-stage release of the asynchronous reset
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_q      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q      <= rst_meta_q;
        end
    end

    // ****************************************************************
    // storage and pending events
    // ****************************************************************
    logic [63:0]             mem_q [NUM_LF];
    logic [63:0]             hf_q  [NUM_HF];
    logic [NUM_LF-1:0][1:0]  pend;
    logic [NUM_LF-1:0]       take;

    stats_pending u_pending (
        .clock_i (clock_i),
        .rst_n_i (rst_q),
        .ce_i    (ce_i),
        .vec_i   (inc_vec_i),
        .take_i  (take),
        .count_o (pend)
    );

    // ****************************************************************
    // sweeper
    // ****************************************************************
    sweep_state_type st_q;
    logic [5:0]      ptr_q;
    logic [5:0]      vis_q;
    logic [63:0]     cur_q;

    // lowest flagged member of a size set, else the base
    function automatic logic [5:0] set_pick(input logic [5:0] base,
                                            input logic [NUM_LF-1:0][1:0] p);
        logic [5:0] pick;
        pick = base;
        for (int i = 6; i >= 0; i--) begin
            if (p[6'(base - FIRST_LF_INDEX + 6'(i))] != 2'h0) begin
                pick = 6'(base + 6'(i));
            end
        end
        return pick;
    endfunction

    wire        at_rx    = (ptr_q == RX_SIZE_BASE);
    wire        at_tx    = (ptr_q == TX_SIZE_BASE);
    wire [5:0]  vis_idx  = (at_rx || at_tx) ? set_pick(ptr_q, pend) : ptr_q;
    wire [5:0]  step_ptr = (at_rx || at_tx) ? 6'(ptr_q + SIZE_SET_LEN)
                                            : 6'(ptr_q + 6'h01);
    wire        at_last  = (ptr_q == LAST_INDEX);
    wire [5:0]  next_ptr = at_last ? FIRST_LF_INDEX : step_ptr;
    wire [5:0]  wr_addr  = 6'(vis_q - FIRST_LF_INDEX);
    wire [5:0]  clr_addr = 6'(ptr_q - FIRST_LF_INDEX);
    wire [1:0]  wr_cnt   = pend[wr_addr];
    wire [63:0] sum      = cur_q + {62'h0, wr_cnt};
    wire [63:0] next_val = WIDE_COUNTERS ? sum : {32'h0, sum[31:0]};
    wire        sweep_on = ce_i && MGMT_ENABLE;
    wire        mem_we   = sweep_on && (st_q != ST_READ);
    wire [5:0]  mem_wa   = (st_q == ST_CLEAR) ? clr_addr : wr_addr;
    wire [63:0] mem_wd   = (st_q == ST_CLEAR) ? COUNT_RESET : next_val;

    // one-hot clear of the pending count being applied
    assign take = (sweep_on && st_q == ST_WRITE) ? (NUM_LF'(1) << wr_addr) : '0;

    // sweep sequence: optional clear pass, then read and write-back
    always_ff @(posedge clock_i or negedge rst_q) begin
        if (!rst_q) begin
            st_q  <= CLEAR_ON_RESET ? ST_CLEAR : ST_READ;
            ptr_q <= FIRST_LF_INDEX;
            vis_q <= FIRST_LF_INDEX;
            cur_q <= COUNT_RESET;
        end else if (sweep_on) begin
            unique case (st_q)
                ST_CLEAR: begin
                    st_q  <= at_last ? ST_READ : ST_CLEAR;
                    ptr_q <= at_last ? FIRST_LF_INDEX : 6'(ptr_q + 6'h01);
                end
                ST_READ: begin
                    st_q  <= ST_WRITE;
                    vis_q <= vis_idx;
                    cur_q <= mem_q[6'(vis_idx - FIRST_LF_INDEX)];
                end
                ST_WRITE: begin
                    st_q  <= ST_READ;
                    ptr_q <= next_ptr;
                end
                default: begin
                    st_q  <= ST_READ;
                end
            endcase
        end
    end

    // counter memory, never reset by itself
    always_ff @(posedge clock_i) begin
        if (mem_we) begin
            mem_q[mem_wa] <= mem_wd;
        end
    end

    // high-rate counters in flops, bumped every cycle if needed
    genvar h;
    generate
        for (h = 0; h < NUM_HF; h++) begin : g_hf
            wire [63:0] hf_sum = hf_q[h] + 64'h1;
            always_ff @(posedge clock_i) begin
                if (sweep_on && st_q == ST_CLEAR) begin
                    hf_q[h] <= COUNT_RESET;
                end else if (sweep_on && hf_inc_i[h]) begin
                    hf_q[h] <= WIDE_COUNTERS ? hf_sum : {32'h0, hf_sum[31:0]};
                end
            end
        end
    endgenerate

    // ****************************************************************
    // read window
    // ****************************************************************
    logic        held_q;
    logic [5:0]  held_idx_q;
    logic [31:0] held_hi_q;

    wire        idx_ok   = (req_i.index <= LAST_INDEX);
    wire        is_hf    = (req_i.index < FIRST_LF_INDEX);
    wire [63:0] rd_val   = is_hf ? hf_q[req_i.index[1:0]]
                                 : mem_q[6'(req_i.index - FIRST_LF_INDEX)];
    wire        rd_lower = req_i.valid && !req_i.write && !req_i.upper;
    wire        up_hit   = held_q && held_idx_q == req_i.index && WIDE_COUNTERS;
    wire        bad      = !MGMT_ENABLE || req_i.write || !idx_ok
                           || (req_i.upper && !up_hit);
    wire        cap_en   = ce_i && rd_lower && !bad && WIDE_COUNTERS;
    wire [31:0] rd_word  = req_i.upper ? held_hi_q : rd_val[31:0];

    // capture of the upper half on a lower read
    always_ff @(posedge clock_i or negedge rst_q) begin
        if (!rst_q) begin
            held_q     <= 1'b0;
            held_idx_q <= FIRST_LF_INDEX;
            held_hi_q  <= DATA_RESET;
        end else if (cap_en) begin
            held_q     <= 1'b1;
            held_idx_q <= req_i.index;
            held_hi_q  <= rd_val[63:32];
        end
    end

    // registered answer; reads leave counters as they are
    always_ff @(posedge clock_i or negedge rst_q) begin
        if (!rst_q) begin
            resp_o <= '0;
        end else if (ce_i) begin
            resp_o.valid <= req_i.valid;
            resp_o.err   <= req_i.valid && bad;
            resp_o.data  <= (req_i.valid && !bad) ? rd_word : DATA_RESET;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_q);

    property p_write_err;
        ce_i && req_i.valid && req_i.write |=> resp_o.valid && resp_o.err;
    endproperty
    a_write_err: assert property (p_write_err)
        else $error("write not answered with error");

    property p_upper_hit;
        ce_i && req_i.valid && !req_i.write && req_i.upper && up_hit && MGMT_ENABLE
            |=> !resp_o.err && resp_o.data == $past(held_hi_q);
    endproperty
    a_upper_hit: assert property (p_upper_hit)
        else $error("upper read did not return captured half");

    property p_upper_miss;
        ce_i && req_i.valid && req_i.upper && !up_hit |=> resp_o.err;
    endproperty
    a_upper_miss: assert property (p_upper_miss)
        else $error("upper read of other counter not errored");

    property p_capture;
        ce_i && rd_lower && idx_ok && !is_hf && MGMT_ENABLE && WIDE_COUNTERS
            |=> held_q && held_hi_q == $past(rd_val[63:32]);
    endproperty
    a_capture: assert property (p_capture)
        else $error("lower read did not capture upper half");

    property p_two_access;
        sweep_on && st_q == ST_READ |=> st_q == ST_WRITE ##1 st_q != ST_WRITE || !$past(ce_i);
    endproperty
    a_two_access: assert property (p_two_access)
        else $error("update not one read then one write");

    property p_write_back;
        sweep_on && st_q == ST_WRITE |=> mem_q[$past(wr_addr)] == $past(next_val);
    endproperty
    a_write_back: assert property (p_write_back)
        else $error("write-back value wrong");

    property p_hf_count;
        sweep_on && st_q != ST_CLEAR && hf_inc_i[0] && WIDE_COUNTERS
            |=> hf_q[0] == $past(hf_q[0]) + 64'h1;
    endproperty
    a_hf_count: assert property (p_hf_count)
        else $error("high-rate counter missed an event");

    property p_set_skip;
        st_q == ST_READ && at_rx |-> vis_idx >= RX_SIZE_BASE
            && vis_idx < 6'(RX_SIZE_BASE + SIZE_SET_LEN);
    endproperty
    a_set_skip: assert property (p_set_skip)
        else $error("size set visit outside its set");

    property p_set_jump;
        sweep_on && st_q == ST_WRITE && at_tx |=> ptr_q == 6'(TX_SIZE_BASE + SIZE_SET_LEN);
    endproperty
    a_set_jump: assert property (p_set_jump)
        else $error("sweep did not skip the rest of the size set");

    property p_disabled;
        resp_o.valid && !MGMT_ENABLE |-> resp_o.err;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("bank answered without management interface");

    property p_clear_end;
        sweep_on && st_q == ST_CLEAR && at_last |=> st_q == ST_READ && ptr_q == FIRST_LF_INDEX;
    endproperty
    a_clear_end: assert property (p_clear_end)
        else $error("clear pass did not hand over to sweep");

    c_upper_hit: cover property (ce_i && req_i.valid && req_i.upper && up_hit);
    c_write_err: cover property (resp_o.valid && resp_o.err && $past(req_i.write));
    c_set_pick:  cover property (st_q == ST_READ && at_rx && vis_idx != RX_SIZE_BASE);
    c_wrap:      cover property (sweep_on && st_q == ST_WRITE && next_val < cur_q);

endmodule // stats_counters
`default_nettype wire

/* src/stats_pkg.sv */
// ****************************************************************
// statistics counter bank constants and types
// ****************************************************************
package stats_pkg;

    // counter map
    localparam int          NUM_HF         = 4;
    localparam int          NUM_LF         = 40;
    localparam logic [5:0]  FIRST_LF_INDEX = 6'h04;
    localparam logic [5:0]  LAST_INDEX     = 6'h2B;
    localparam logic [5:0]  SIZE_SET_LEN   = 6'h07;
    localparam logic [5:0]  RX_SIZE_BASE   = 6'h0C;
    localparam logic [5:0]  TX_SIZE_BASE   = 6'h1C;

    // pending events per counter saturate here
    localparam logic [1:0]  PEND_MAX       = 2'h3;

    // values after reset
    localparam logic [63:0] COUNT_RESET    = 64'h0;
    localparam logic [31:0] DATA_RESET     = 32'h0;

    // one access to the read window
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       upper;
        logic [5:0] index;
    } stats_req_type;

    // answer one cycle after the request
    typedef struct packed {
        logic        valid;
        logic        err;
        logic [31:0] data;
    } stats_resp_type;

    // sweeper states
    typedef enum logic [1:0] {
        ST_CLEAR = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b11
    } sweep_state_type;

endpackage

/* src/stats_pending.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// toggle detection and pending event counts, one per counter
// ****************************************************************
module stats_pending
    import stats_pkg::*;
(
    // clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   ce_i,
    // increment toggles and sweeper clears
    input  wire logic [NUM_LF-1:0]      vec_i,
    input  wire logic [NUM_LF-1:0]      take_i,
    // pending counts
    output logic      [NUM_LF-1:0][1:0] count_o
);

    logic              armed_q;
    logic [NUM_LF-1:0] prev_q;
    logic [NUM_LF-1:0] tog;

    // first cycle after reset only loads the reference levels
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed_q <= 1'b0;
            prev_q  <= '0;
        end else if (ce_i) begin
            armed_q <= 1'b1;
            prev_q  <= vec_i;
        end
    end

    // either edge is one event
    assign tog = armed_q ? (vec_i ^ prev_q) : '0;

    genvar k;
    generate
        for (k = 0; k < NUM_LF; k++) begin : g_bit
            logic [1:0] cnt_q;
            logic [1:0] left;
            logic [1:0] cnt_d;
            // a toggle in the clearing cycle survives
            assign left  = take_i[k] ? 2'h0 : cnt_q;
            assign cnt_d = (tog[k] && left != PEND_MAX) ? 2'(left + 2'h1) : left;
            always_ff @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    cnt_q <= 2'h0;
                end else if (ce_i) begin
                    cnt_q <= cnt_d;
                end
            end
            assign count_o[k] = cnt_q;
        end
    endgenerate

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    property p_toggle_counts;
        ce_i && tog[0] && !take_i[0] && count_o[0] != PEND_MAX
            |=> count_o[0] == $past(count_o[0]) + 2'h1;
    endproperty
    a_toggle_counts: assert property (p_toggle_counts)
        else $error("toggle did not raise pending count");

    property p_toggle_held;
        ce_i && tog[0] && take_i[0] |=> count_o[0] == 2'h1;
    endproperty
    a_toggle_held: assert property (p_toggle_held)
        else $error("toggle lost during sweeper clear");

    property p_quiet;
        ce_i && armed_q && vec_i[0] == prev_q[0] && take_i[0] |=> count_o[0] == 2'h0;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("pending count left after clear without toggle");

endmodule // stats_pending
`default_nettype wire

/* test/stats_decode_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// vector decode stand-in: one toggle per requested event
// ****************************************************************
module stats_decode_model
    import stats_pkg::*;
(
    // clock
    input  wire logic                  clock_i,
    // events to signal, one bit per low-frequency counter
    input  wire logic [NUM_LF-1:0]     flip_i,
    // increment toggle bus
    output logic      [NUM_LF-1:0]     inc_vec_o
);
    import stats_pkg::*;

    // known level on every bit from the start
    logic [NUM_LF-1:0] level_q = '0;

    // each event inverts its own bit, either direction counts
    always_ff @(posedge clock_i) begin
        level_q <= level_q ^ flip_i;
    end

    assign inc_vec_o = level_q;

endmodule // stats_decode_model
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// self-checking bench for the statistics counter bank
// ****************************************************************
module tb;
    import stats_pkg::*;

    logic                  clock;
    logic                  rst_n;
    logic                  ce;
    logic [NUM_HF-1:0]     hf_inc;
    logic [NUM_LF-1:0]     inc_vec;
    logic [NUM_LF-1:0]     flip;
    stats_req_type         req;
    stats_resp_type        resp;
    stats_resp_type        resp_n;
    stats_resp_type        resp_off;
    logic [63:0]           expect_q [0:43];
    int                    num_errors;
    int                    tests_run;

    // ****************************************************************
    // design and far side
    // ****************************************************************
    stats_counters stats_counters_i (
        .clock_i   (clock),
        .rst_n_i   (rst_n),
        .ce_i      (ce),
        .hf_inc_i  (hf_inc),
        .inc_vec_i (inc_vec),
        .req_i     (req),
        .resp_o    (resp)
    );

    // narrow counters: upper halves refused, lower halves as above
    stats_counters #(
        .WIDE_COUNTERS (1'b0)
    ) stats_counters_narrow_i (
        .clock_i   (clock),
        .rst_n_i   (rst_n),
        .ce_i      (ce),
        .hf_inc_i  (hf_inc),
        .inc_vec_i (inc_vec),
        .req_i     (req),
        .resp_o    (resp_n)
    );

    // management interface off: every access refused
    stats_counters #(
        .MGMT_ENABLE (1'b0)
    ) stats_counters_off_i (
        .clock_i   (clock),
        .rst_n_i   (rst_n),
        .ce_i      (ce),
        .hf_inc_i  (hf_inc),
        .inc_vec_i (inc_vec),
        .req_i     (req),
        .resp_o    (resp_off)
    );

    stats_decode_model stats_decode_model_i (
        .clock_i   (clock),
        .flip_i    (flip),
        .inc_vec_o (inc_vec)
    );

    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    // verdict and end of run
    task automatic complete_run();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one access to the read window, answer checked one cycle later
    task automatic access(input logic w, input logic u, input logic [5:0] idx,
                          input logic e, input logic [31:0] d);
        stats_resp_type want;
        stats_resp_type want_n;
        stats_resp_type want_off;
        want     = '{valid: 1'b1, err: e, data: d};
        want_n   = '{valid: 1'b1, err: e || u, data: (e || u) ? DATA_RESET : d};
        want_off = '{valid: 1'b1, err: 1'b1, data: DATA_RESET};
        @(posedge clock);
        req <= '{valid: 1'b1, write: w, upper: u, index: idx};
        @(posedge clock);
        req <= '0;
        #1;
        tests_run++;
        if (resp !== want) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, resp, want);
        end
        if (resp_n !== want_n) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, resp_n, want_n);
        end
        if (resp_off !== want_off) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, resp_off, want_off);
        end
    endtask

    // expected half of one counter
    function automatic logic [31:0] half_of(input int idx, input logic u);
        return u ? expect_q[idx][63:32] : expect_q[idx][31:0];
    endfunction

    // both halves of every counter against the expected values
    task automatic check_all();
        for (int i = 0; i < 44; i++) begin
            access(1'b0, 1'b0, 6'(i), 1'b0, half_of(i, 1'b0));
            access(1'b0, 1'b1, 6'(i), 1'b0, half_of(i, 1'b1));
        end
    endtask

    // random high-frequency events, possibly every cycle
    task automatic hf_burst(input int n);
        logic [3:0] v;
        repeat (n) begin
            @(posedge clock);
            v = 4'($urandom);
            hf_inc <= v;
            for (int k = 0; k < 4; k++) expect_q[k] += 64'(v[k]);
        end
        @(posedge clock);
        hf_inc <= '0;
    endtask

    // one toggle on each chosen bit, flip cleared again on the next cycle
    task automatic toggle(input logic [NUM_LF-1:0] m);
        @(posedge clock);
        flip <= m;
        for (int j = 0; j < NUM_LF; j++) expect_q[j+4] += 64'(m[j]);
        @(posedge clock);
        flip <= '0;
    endtask

    // bus reset and expected values back to zero
    task automatic do_reset();
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 44; i++) expect_q[i] = COUNT_RESET;
        repeat (60) @(posedge clock);
    endtask

    // ****************************************************************
    // watchdog
    // ****************************************************************
    initial begin
        repeat (30000) @(posedge clock);
        num_errors++;
        complete_run();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rst_n      = 1'b0;
        ce         = 1'b1;
        hf_inc     = '0;
        flip       = '0;
        req        = '0;
        num_errors = 0;
        tests_run  = 0;
        void'($urandom(28796));
        for (int i = 0; i < 44; i++) expect_q[i] = COUNT_RESET;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (60) @(posedge clock);
        check_all();

        // every-cycle sources on counters 0 to 3
        hf_burst(40);
        repeat (4) @(posedge clock);
        check_all();

        // random rounds of toggles, size sets included
        for (int r = 0; r < 3; r++) begin
            toggle(NUM_LF'({$urandom, $urandom}));
            repeat (500) @(posedge clock);
            check_all();
        end
        // whole size sets pending at once, and every bit at once
        toggle(NUM_LF'(40'h00_7F00_7F00));
        repeat (500) @(posedge clock);
        toggle({NUM_LF{1'b1}});
        repeat (500) @(posedge clock);
        check_all();

        // second toggle while the first is still pending
        toggle(NUM_LF'(40'h00_0000_0100));
        repeat (2) @(posedge clock);
        toggle(NUM_LF'(40'h00_0000_0100));
        toggle(NUM_LF'(40'h00_0000_0100));
        repeat (200) @(posedge clock);
        check_all();

        // enable low freezes answers, sweep and toggle detection
        @(posedge clock);
        ce  <= 1'b0;
        req <= '{valid: 1'b1, write: 1'b0, upper: 1'b0, index: 6'h04};
        toggle(NUM_LF'(40'h00_0000_0001));
        repeat (20) @(posedge clock);
        #1;
        tests_run++;
        if (resp !== '0) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, resp, 34'h0);
        end
        @(posedge clock);
        ce  <= 1'b1;
        req <= '0;
        repeat (200) @(posedge clock);
        check_all();

        // upper half of another counter is refused
        access(1'b0, 1'b0, 6'h09, 1'b0, expect_q[9][31:0]);
        access(1'b0, 1'b1, 6'h0A, 1'b1, DATA_RESET);
        // writes refused and harmless, unmapped places refused
        access(1'b1, 1'b0, 6'h05, 1'b1, DATA_RESET);
        access(1'b1, 1'b1, 6'h01, 1'b1, DATA_RESET);
        access(1'b0, 1'b0, 6'h2C, 1'b1, DATA_RESET);
        access(1'b0, 1'b0, 6'h3F, 1'b1, DATA_RESET);
        access(1'b0, 1'b0, 6'h05, 1'b0, expect_q[5][31:0]);
        access(1'b0, 1'b1, 6'h05, 1'b0, expect_q[5][63:32]);
        access(1'b0, 1'b1, 6'h05, 1'b0, expect_q[5][63:32]);

        // reset mid-run drops counts, pendings and the capture
        access(1'b0, 1'b0, 6'h09, 1'b0, expect_q[9][31:0]);
        toggle(NUM_LF'(40'h00_0000_0020));
        do_reset();
        access(1'b0, 1'b1, 6'h09, 1'b1, DATA_RESET);
        check_all();
        hf_burst(20);
        toggle(NUM_LF'({$urandom, $urandom}));
        repeat (500) @(posedge clock);
        check_all();
        complete_run();
    end

endmodule // tb
`default_nettype wire
